// *** dbg_hs_device.sv ***
// target end: acknowledge pulses, sync response and command abort
// Contract
// - host aborts with low of 128+ cycles, speedup
// - long low runs sync, aborts pending command
// - sync during access latency drops only ack
// - resume, run-until, step never cancelled
// - short low cancels command at falling edge
// - short abort low lasts at least 4 cycles
// - short abort on non-read starts new command
// - no target timeout; host aborts missing acks
// - host sync pulse slightly over 128 cycles
// - handshake on/off commands; off after reset
// - handshake-on command itself is acknowledged
// - handshake off: host waits worst-case delay
// - read acks when bus cycle done
// - write acks after data and bus cycle
// - halt request acks on entering background
// - resume acks on leaving background
// - run-until acks on next background entry
// - single step acks on background re-entry
// - no arbitration between ack and sync
`default_nettype none

module dbg_hs_device (
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  dbg_wire_if.device                link,
  input  wire logic                 cmd_go,
  input  wire dbg_hs_pkg::cmd_kind_t cmd_kind,
  input  wire logic                 access_busy,
  input  wire logic                 access_done,
  input  wire logic                 cpu_bdm,
  output logic                      hs_enabled,
  output logic                      ack_active,
  output logic                      sync_active,
  output logic                      cmd_abort,
  output logic                      cmd_edge,
  output logic                      sync_seen
);
  import dbg_hs_pkg::*;

  typedef struct packed {
    dev_state_t st;
    logic [7:0] cnt;
    logic [7:0] low_cnt;
    logic       pin_q;
    logic       bdm_q;
    logic       ack_en;
    logic       pend_v;
    cmd_kind_t  pend;
    logic       ack_due;
    logic       abort_p;
    logic       edge_p;
    logic       sync_p;
  } dev_reg_t;

  localparam dev_reg_t DEV_RESET = '{
    st:      DS_IDLE,
    cnt:     8'h00,
    low_cnt: RESET_LOW_CNT,
    pin_q:   1'b1,
    bdm_q:   1'b0,
    ack_en:  1'b0,
    pend_v:  1'b0,
    pend:    CMD_READ,
    ack_due: 1'b0,
    abort_p: 1'b0,
    edge_p:  1'b0,
    sync_p:  1'b0
  };

  dev_reg_t r_ff;
  dev_reg_t nxt_r;

  logic fall;
  logic rise;
  logic fire;
  logic pend_rw;

  ////////////////////////////////////////////////////////////////////////
  // pin edges and completion events

  assign fall    = r_ff.pin_q & ~link.pin;
  assign rise    = ~r_ff.pin_q & link.pin;
  assign pend_rw = r_ff.pend_v &
                   ((r_ff.pend == CMD_READ) | (r_ff.pend == CMD_WRITE));

  always_comb begin
    case (r_ff.pend)
      CMD_READ:      fire = access_done;
      CMD_WRITE:     fire = access_done;
      CMD_HALT:      fire = cpu_bdm & ~r_ff.bdm_q;
      CMD_RESUME:    fire = ~cpu_bdm & r_ff.bdm_q;
      CMD_RUN_UNTIL: fire = cpu_bdm & ~r_ff.bdm_q;
      CMD_STEP:      fire = cpu_bdm & ~r_ff.bdm_q;
      default:       fire = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_r         = r_ff;
    nxt_r.pin_q   = link.pin;
    nxt_r.bdm_q   = cpu_bdm;
    nxt_r.abort_p = 1'b0;
    nxt_r.edge_p  = 1'b0;
    nxt_r.sync_p  = 1'b0;

    // ack only goes out if the handshake is on when the event lands
    if (r_ff.pend_v && fire) begin
      nxt_r.pend_v = 1'b0;
      if (r_ff.ack_en) begin
        nxt_r.ack_due = 1'b1;
      end
    end

    if (cmd_go) begin
      case (cmd_kind)
        CMD_HS_ON: begin
          nxt_r.ack_en  = 1'b1;
          nxt_r.ack_due = 1'b1;
          nxt_r.pend_v  = 1'b0;
        end
        CMD_HS_OFF: begin
          nxt_r.ack_en  = 1'b0;
          nxt_r.ack_due = 1'b0;
          nxt_r.pend_v  = 1'b0;
        end
        default: begin
          nxt_r.pend_v = 1'b1;
          nxt_r.pend   = cmd_kind;
        end
      endcase
    end

    // pin watch only while the target is not driving or answering
    if (r_ff.st == DS_IDLE) begin
      if (!link.pin) begin
        if (r_ff.low_cnt != LONG_LOW_CYC) begin
          nxt_r.low_cnt = r_ff.low_cnt + 8'h01;
        end
      end else begin
        nxt_r.low_cnt = RESET_LOW_CNT;
      end

      // any falling edge kills the pending ack, long or short
      if (fall) begin
        nxt_r.ack_due = 1'b0;
        nxt_r.pend_v  = 1'b0;
        // an access already under way finishes; only its ack goes
        if (pend_rw && !access_busy) begin
          nxt_r.abort_p = 1'b1;
        end
        // every falling edge starts a new command unless a read is pending
        if (!(r_ff.pend_v && r_ff.pend == CMD_READ)) begin
          nxt_r.edge_p = 1'b1;
        end
      end

      if (rise && r_ff.low_cnt == LONG_LOW_CYC) begin
        nxt_r.sync_p  = 1'b1;
        nxt_r.st      = DS_SYNC_WAIT;
        nxt_r.cnt     = 8'h00;
        nxt_r.ack_due = 1'b0;
      end else if (rise) begin
        nxt_r.low_cnt = RESET_LOW_CNT;
      end
    end

    case (r_ff.st)
      DS_IDLE: begin
        // ack starts only while the pin is high now and was high last cycle
        if (r_ff.ack_due && link.pin && r_ff.pin_q && !fall) begin
          nxt_r.st      = DS_ACK_LO;
          nxt_r.cnt     = 8'h00;
          nxt_r.ack_due = 1'b0;
        end
      end
      DS_ACK_LO: begin
        nxt_r.cnt = r_ff.cnt + 8'h01;
        if (r_ff.cnt == ACK_LO_CYC - 8'h01) begin
          nxt_r.st  = DS_ACK_HI;
          nxt_r.cnt = 8'h00;
        end
      end
      DS_ACK_HI: begin
        nxt_r.cnt = r_ff.cnt + 8'h01;
        if (r_ff.cnt == SPEEDUP_CYC - 8'h01) begin
          nxt_r.st      = DS_IDLE;
          nxt_r.cnt     = 8'h00;
          nxt_r.low_cnt = RESET_LOW_CNT;
        end
      end
      DS_SYNC_WAIT: begin
        nxt_r.cnt = r_ff.cnt + 8'h01;
        if (r_ff.cnt == SYNC_DLY_CYC - 8'h01) begin
          nxt_r.st  = DS_SYNC_LO;
          nxt_r.cnt = 8'h00;
        end
      end
      DS_SYNC_LO: begin
        nxt_r.cnt = r_ff.cnt + 8'h01;
        if (r_ff.cnt == SYNC_LO_CYC - 8'h01) begin
          nxt_r.st  = DS_SYNC_HI;
          nxt_r.cnt = 8'h00;
        end
      end
      DS_SYNC_HI: begin
        nxt_r.cnt = r_ff.cnt + 8'h01;
        if (r_ff.cnt == SPEEDUP_CYC - 8'h01) begin
          nxt_r.st      = DS_IDLE;
          nxt_r.cnt     = 8'h00;
          nxt_r.low_cnt = RESET_LOW_CNT;
        end
      end
      default: begin
        nxt_r.st  = DS_IDLE;
        nxt_r.cnt = 8'h00;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      r_ff <= DEV_RESET;
    end else begin
      r_ff <= nxt_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drive and user outputs

  always_comb begin
    case (r_ff.st)
      DS_ACK_LO: begin
        link.dev_o  = 1'b0;
        link.dev_oe = 1'b1;
      end
      DS_SYNC_LO: begin
        link.dev_o  = 1'b0;
        link.dev_oe = 1'b1;
      end
      DS_ACK_HI: begin
        link.dev_o  = 1'b1;
        link.dev_oe = 1'b1;
      end
      DS_SYNC_HI: begin
        link.dev_o  = 1'b1;
        link.dev_oe = 1'b1;
      end
      default: begin
        link.dev_o  = 1'b1;
        link.dev_oe = 1'b0;
      end
    endcase
  end

  assign hs_enabled  = r_ff.ack_en;
  assign ack_active  = (r_ff.st == DS_ACK_LO) | (r_ff.st == DS_ACK_HI);
  assign sync_active = (r_ff.st == DS_SYNC_WAIT) |
                       (r_ff.st == DS_SYNC_LO) |
                       (r_ff.st == DS_SYNC_HI);
  assign cmd_abort   = r_ff.abort_p;
  assign cmd_edge    = r_ff.edge_p;
  assign sync_seen   = r_ff.sync_p;

endmodule

`default_nettype wire

// *** dbg_hs_pkg.sv ***
// constants and types for the debug wire handshake and abort logic
`default_nettype none

package dbg_hs_pkg;

  // command kinds reported by the target's serial command decoder
  typedef enum logic [2:0] {
    CMD_READ      = 3'b000,
    CMD_WRITE     = 3'b001,
    CMD_HALT      = 3'b010,
    CMD_RESUME    = 3'b011,
    CMD_RUN_UNTIL = 3'b100,
    CMD_STEP      = 3'b101,
    CMD_HS_ON     = 3'b110,
    CMD_HS_OFF    = 3'b111
  } cmd_kind_t;

  typedef enum logic [2:0] {
    DS_IDLE      = 3'b000,
    DS_ACK_LO    = 3'b001,
    DS_ACK_HI    = 3'b010,
    DS_SYNC_WAIT = 3'b011,
    DS_SYNC_LO   = 3'b100,
    DS_SYNC_HI   = 3'b101
  } dev_state_t;

  typedef enum logic [2:0] {
    HS_IDLE     = 3'b000,
    HS_AB_LO    = 3'b001,
    HS_AB_HI    = 3'b010,
    HS_SY_WAIT  = 3'b011,
    HS_SY_MEAS  = 3'b100,
    HS_WAIT_ACK = 3'b101,
    HS_WAIT_DLY = 3'b110
  } host_state_t;

  // device side counts, in serial clock cycles (one per clk_sys)
  localparam logic [7:0]  LONG_LOW_CYC  = 8'h80;  // sync threshold, 128
  localparam logic [7:0]  ACK_LO_CYC    = 8'h10;
  localparam logic [7:0]  SPEEDUP_CYC   = 8'h01;
  localparam logic [7:0]  SYNC_DLY_CYC  = 8'h10;
  localparam logic [7:0]  SYNC_LO_CYC   = 8'h80;
  localparam logic [7:0]  RESET_LOW_CNT = 8'h00;

  // host side counts
  localparam logic [11:0] SHORT_LO_CYC  = 12'h004;
  localparam logic [11:0] SYNC_MARGIN   = 12'h004;
  localparam logic [11:0] HOST_SYNC_CYC = 12'h080 + SYNC_MARGIN;
  localparam logic [11:0] HOST_HI_CYC   = 12'h001;
  localparam logic [11:0] WORST_DLY_CYC = 12'h400;
  localparam logic [11:0] ACK_TMO_CYC   = 12'h800;
  localparam logic [11:0] SYNC_TMO_CYC  = 12'h800;

endpackage

`default_nettype wire

// *** dbg_wire_if.sv ***
// single debug wire between target and probe, open-drain with pull-up
`default_nettype none

interface dbg_wire_if;
  logic pin;
  logic dev_o;
  logic dev_oe;
  logic host_o;
  logic host_oe;

  // low wins; a clash between speedup and sync pulses reads low
  assign pin = ~((dev_oe & ~dev_o) | (host_oe & ~host_o));

  modport device (
    input  pin,
    output dev_o,
    output dev_oe
  );

  modport host (
    input  pin,
    output host_o,
    output host_oe
  );
endinterface

`default_nettype wire

// *** dbg_hs_host.sv ***
// probe end: abort pulses, sync measurement, ack or delay waits
`default_nettype none

module dbg_hs_host (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  dbg_wire_if.host         link,
  input  wire logic        abort_go,
  input  wire logic        abort_short,
  input  wire logic        wait_go,
  input  wire logic        hs_on,
  input  wire logic        tx_low,
  output logic             busy,
  output logic             wait_done,
  output logic             ack_missing,
  output logic             abort_done,
  output logic [7:0]       sync_len
);
  import dbg_hs_pkg::*;

  typedef struct packed {
    host_state_t st;
    logic [11:0] cnt;
    logic        short_q;
    logic        pin_q;
    logic [7:0]  len;
    logic        wait_p;
    logic        miss_p;
    logic        done_p;
  } host_reg_t;

  localparam host_reg_t HOST_RESET = '{
    st:      HS_IDLE,
    cnt:     12'h000,
    short_q: 1'b0,
    pin_q:   1'b1,
    len:     8'h00,
    wait_p:  1'b0,
    miss_p:  1'b0,
    done_p:  1'b0
  };

  host_reg_t r_ff;
  host_reg_t nxt_r;
  logic      fall;
  logic [11:0] lo_end;

  assign fall   = r_ff.pin_q & ~link.pin;
  // short pulse is long enough for the target to see its edge
  assign lo_end = r_ff.short_q ? SHORT_LO_CYC : HOST_SYNC_CYC;

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    nxt_r        = r_ff;
    nxt_r.pin_q  = link.pin;
    nxt_r.wait_p = 1'b0;
    nxt_r.miss_p = 1'b0;
    nxt_r.done_p = 1'b0;
    nxt_r.cnt    = r_ff.cnt + 12'h001;

    case (r_ff.st)
      HS_IDLE: begin
        nxt_r.cnt = 12'h000;
        if (abort_go) begin
          nxt_r.st      = HS_AB_LO;
          nxt_r.short_q = abort_short;
        end else if (wait_go) begin
          nxt_r.st = hs_on ? HS_WAIT_ACK : HS_WAIT_DLY;
        end
      end
      HS_AB_LO: begin
        if (r_ff.cnt == lo_end - 12'h001) begin
          nxt_r.st  = HS_AB_HI;
          nxt_r.cnt = 12'h000;
        end
      end
      HS_AB_HI: begin
        if (r_ff.cnt == HOST_HI_CYC - 12'h001) begin
          nxt_r.cnt = 12'h000;
          nxt_r.len = 8'h00;
          if (r_ff.short_q) begin
            nxt_r.st     = HS_IDLE;
            nxt_r.done_p = 1'b1;
          end else begin
            nxt_r.st = HS_SY_WAIT;
          end
        end
      end
      HS_SY_WAIT: begin
        // a dead target must not hang the probe
        if (fall) begin
          nxt_r.st  = HS_SY_MEAS;
          nxt_r.len = 8'h01;
        end else if (r_ff.cnt == SYNC_TMO_CYC - 12'h001) begin
          nxt_r.st     = HS_IDLE;
          nxt_r.done_p = 1'b1;
        end
      end
      HS_SY_MEAS: begin
        if (!link.pin) begin
          if (r_ff.len != 8'hff) begin
            nxt_r.len = r_ff.len + 8'h01;
          end
        end else begin
          nxt_r.st     = HS_IDLE;
          nxt_r.done_p = 1'b1;
        end
      end
      HS_WAIT_ACK: begin
        if (fall) begin
          nxt_r.st     = HS_IDLE;
          nxt_r.wait_p = 1'b1;
        end else if (r_ff.cnt == ACK_TMO_CYC - 12'h001) begin
          // target never times out, so the probe aborts itself
          nxt_r.miss_p  = 1'b1;
          nxt_r.st      = HS_AB_LO;
          nxt_r.short_q = 1'b0;
          nxt_r.cnt     = 12'h000;
        end
      end
      HS_WAIT_DLY: begin
        if (r_ff.cnt == WORST_DLY_CYC - 12'h001) begin
          nxt_r.st     = HS_IDLE;
          nxt_r.wait_p = 1'b1;
        end
      end
      default: begin
        nxt_r.st  = HS_IDLE;
        nxt_r.cnt = 12'h000;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      r_ff <= HOST_RESET;
    end else begin
      r_ff <= nxt_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pin drive and user outputs

  assign link.host_o  = (r_ff.st == HS_AB_HI);
  assign link.host_oe = (r_ff.st == HS_AB_LO) | (r_ff.st == HS_AB_HI) |
                        ((r_ff.st == HS_IDLE) & tx_low);
  assign busy         = (r_ff.st != HS_IDLE);
  assign wait_done    = r_ff.wait_p;
  assign ack_missing  = r_ff.miss_p;
  assign abort_done   = r_ff.done_p;
  assign sync_len     = r_ff.len;

endmodule

`default_nettype wire

// *** dbg_hs_sva.sv ***
// wire checks: pulse shapes, low lengths and the sync reply
`default_nettype none

module dbg_hs_sva (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic pin,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic host_o,
  input wire logic host_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] dlo_ff;
  logic [7:0] hlo_ff;
  logic       clash_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////
  // low-run counters; a clash voids the sync expectation
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dlo_ff   <= 8'h00;
      hlo_ff   <= 8'h00;
      clash_ff <= 1'b0;
    end else begin
      dlo_ff   <= (dev_oe && !dev_o) ? dlo_ff + 8'h01 : 8'h00;
      hlo_ff   <= (host_oe && !host_o) ? hlo_ff + 8'h01 : 8'h00;
      clash_ff <= host_oe ? (clash_ff | dev_oe) : 1'b0;
    end
  end

  property p_dev_low_len;
    (dev_oe && dev_o && dlo_ff != 8'h00) |->
      (dlo_ff == 8'h10 || dlo_ff == 8'h80);
  endproperty
  a_dev_low_len: assert property (p_dev_low_len)
    else $error("device low run has a wrong length");

  property p_dev_spd_rel;
    (dev_oe && dev_o) |=> !dev_oe;
  endproperty
  a_dev_spd_rel: assert property (p_dev_spd_rel)
    else $error("device speedup longer than one cycle");

  property p_dev_start_low;
    $rose(dev_oe) |-> (!dev_o && !pin);
  endproperty
  a_dev_start_low: assert property (p_dev_start_low)
    else $error("device drive did not start low");

  property p_dev_rel_high;
    $fell(dev_oe) |-> $past(dev_o);
  endproperty
  a_dev_rel_high: assert property (p_dev_rel_high)
    else $error("device released without speedup");

  property p_host_low_len;
    (host_oe && host_o && hlo_ff != 8'h00) |->
      (hlo_ff == 8'h04 || hlo_ff == 8'h84);
  endproperty
  a_host_low_len: assert property (p_host_low_len)
    else $error("host abort low has a wrong length");

  property p_host_spd_rel;
    (host_oe && host_o) |=> !host_oe;
  endproperty
  a_host_spd_rel: assert property (p_host_spd_rel)
    else $error("host speedup longer than one cycle");

  property p_host_start_low;
    $rose(host_oe) |-> !host_o;
  endproperty
  a_host_start_low: assert property (p_host_start_low)
    else $error("host drive did not start low");

  // a sync reply is owed only when the device kept off the wire
  property p_sync_resp;
    (host_oe && host_o && hlo_ff == 8'h84 && !clash_ff) |->
      ##[1:40] (dev_oe && !dev_o);
  endproperty
  a_sync_resp: assert property (p_sync_resp)
    else $error("no sync reply after long low");

  c_ack: cover property (dev_oe && dev_o && dlo_ff == 8'h10);
  c_sync: cover property (dev_oe && dev_o && dlo_ff == 8'h80);
  c_short: cover property (host_oe && host_o && hlo_ff == 8'h04);
endmodule

`default_nettype wire

// *** debug_wire_handshake_abort_tb.sv ***
// bench: target and probe ends joined by one wire
`default_nettype none

module debug_wire_handshake_abort_tb;
  import dbg_hs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys     = 1'b0;
  logic       rstn        = 1'b0;
  logic       cmd_go      = 1'b0;
  cmd_kind_t  cmd_kind    = CMD_READ;
  logic       access_busy = 1'b0;
  logic       access_done = 1'b0;
  logic       cpu_bdm     = 1'b0;
  logic       abort_go    = 1'b0;
  logic       abort_short = 1'b0;
  logic       wait_go     = 1'b0;
  logic       hs_on       = 1'b0;
  logic       tx_low      = 1'b0;
  logic       hs_enabled, ack_active, cmd_abort, cmd_edge, sync_seen;
  logic       sync_active, busy;
  logic       wait_done, ack_missing, abort_done;
  logic [7:0] sync_len;
  int         errors      = 0;
  int         check_count = 0;
  int         n_ack, n_abort, n_edge, n_sync, n_sact, t;

  dbg_wire_if i_dbg_wire_if ();
  dbg_hs_device i_dbg_hs_device (.clk_sys, .rstn, .link(i_dbg_wire_if),
    .cmd_go, .cmd_kind, .access_busy, .access_done, .cpu_bdm, .hs_enabled,
    .ack_active, .sync_active, .cmd_abort, .cmd_edge, .sync_seen);
  // tx_low stands in for command bits sent by the probe
  dbg_hs_host i_dbg_hs_host (.clk_sys, .rstn, .link(i_dbg_wire_if),
    .abort_go, .abort_short, .wait_go, .hs_on, .tx_low, .busy,
    .wait_done, .ack_missing, .abort_done, .sync_len);
  dbg_hs_sva i_dbg_hs_sva (.clk_sys, .rstn, .pin(i_dbg_wire_if.pin),
    .dev_o(i_dbg_wire_if.dev_o), .dev_oe(i_dbg_wire_if.dev_oe),
    .host_o(i_dbg_wire_if.host_o), .host_oe(i_dbg_wire_if.host_oe));

  always #2.5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    n_ack   += (ack_active === 1'b1);
    n_abort += (cmd_abort === 1'b1);
    n_edge  += (cmd_edge === 1'b1);
    n_sync  += (sync_seen === 1'b1);
    n_sact  += (sync_active === 1'b1);
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    if (errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic clr;
    #1;
    n_ack   = 0;
    n_abort = 0;
    n_edge  = 0;
    n_sync  = 0;
    n_sact  = 0;
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return ack_active;
      1: return wait_done;
      2: return abort_done;
      default: return ack_missing;
    endcase
  endfunction

  task automatic wait_sig(input int s, input int lim, output int n);
    n = 0;
    while (sig(s) !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n > lim) begin
        errors++;
        $display("[ERR] wait on %0d expected 1 seen 0", s);
        complete_run();
      end
    end
  endtask

  task automatic cmd(input cmd_kind_t k);
    @(posedge clk_sys);
    cmd_go   <= 1'b1;
    cmd_kind <= k;
    @(posedge clk_sys);
    cmd_go   <= 1'b0;
  endtask

  // 0 access done, 1 enter, 2 leave, 4 leave and re-enter background
  task automatic stim(input int ev);
    @(posedge clk_sys);
    case (ev)
      0: begin
        access_done <= 1'b1;
        access_busy <= 1'b0;
      end
      1: cpu_bdm <= 1'b1;
      2, 4: cpu_bdm <= 1'b0;
      default: ;
    endcase
    @(posedge clk_sys);
    access_done <= 1'b0;
    if (ev == 4)
      cpu_bdm <= 1'b1;
  endtask

  task automatic ack_case(input cmd_kind_t k, input int ev, input bit e);
    int n;
    cmd(k);
    clr();
    cyc(3);
    stim(ev);
    if (e)
      wait_sig(0, 4, n);
    cyc(30);
    chk("ack_cycles", n_ack, e ? 17 : 0);
  endtask

  task automatic go_pulse(input logic h);
    @(posedge clk_sys);
    wait_go <= 1'b1;
    hs_on   <= h;
    @(posedge clk_sys);
    wait_go <= 1'b0;
  endtask

  task automatic ab_case(input cmd_kind_t k, input bit b, s,
                         input int ev, ea, ee, es);
    int n;
    cmd(k);
    access_busy <= b;
    clr();
    @(posedge clk_sys);
    abort_go    <= 1'b1;
    abort_short <= s;
    @(posedge clk_sys);
    abort_go    <= 1'b0;
    wait_sig(2, 400, n);
    chk("busy", busy, 0);
    cyc(20);
    stim(ev);
    cyc(30);
    chk("cmd_abort", n_abort, ea);
    chk("cmd_edge", n_edge, ee);
    chk("sync_seen", n_sync, es);
    chk("sync_active", n_sact, es ? 145 : 0);
    chk("ack_cycles", n_ack, 0);
    if (!s)
      chk("sync_len", sync_len >= 8'h7e && sync_len <= 8'h82, 1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    cyc(2);
    #1;
    chk("hs_enabled", hs_enabled, 0);
    ack_case(CMD_READ, 0, 0);
    // probe must already wait, or it misses the ack's falling edge
    go_pulse(1'b1);
    clr();
    cmd(CMD_HS_ON);
    wait_sig(1, 60, t);
    cyc(30);
    chk("hs_enabled", hs_enabled, 1);
    chk("ack_cycles", n_ack, 17);
    ack_case(CMD_READ, 0, 1);
    ack_case(CMD_WRITE, 0, 1);
    ack_case(CMD_HALT, 1, 1);
    ack_case(CMD_RESUME, 2, 1);
    ack_case(CMD_RUN_UNTIL, 1, 1);
    ack_case(CMD_STEP, 4, 1);
    ab_case(CMD_RESUME, 0, 0, 2, 0, 1, 1);
    ab_case(CMD_HALT, 0, 0, 1, 0, 1, 1);
    ab_case(CMD_READ, 0, 0, 3, 1, 0, 1);
    ab_case(CMD_WRITE, 1, 0, 0, 0, 1, 1);
    ab_case(CMD_WRITE, 0, 1, 3, 1, 1, 0);
    ab_case(CMD_READ, 0, 1, 3, 1, 0, 0);
    cmd(CMD_RUN_UNTIL);
    clr();
    go_pulse(1'b1);
    wait_sig(3, 2100, t);
    wait_sig(2, 400, t);
    cyc(30);
    chk("sync_seen", n_sync, 1);
    chk("sync_active", n_sact, 145);
    chk("ack_cycles", n_ack, 0);
    cmd(CMD_HS_OFF);
    ack_case(CMD_WRITE, 0, 0);
    chk("hs_enabled", hs_enabled, 0);
    clr();
    @(posedge clk_sys);
    tx_low <= 1'b1;
    cyc(4);
    tx_low <= 1'b0;
    cyc(30);
    chk("cmd_edge", n_edge, 1);
    chk("cmd_abort", n_abort, 0);
    chk("sync_seen", n_sync, 0);
    go_pulse(1'b0);
    wait_sig(1, 1100, t);
    chk("delay_wait", t >= 1020 && t <= 1030, 1);
    complete_run();
  end
endmodule

`default_nettype wire
